/* File: logic/display_refresh_pkg.sv */
// Constants shared by the multiplexed display refresh logic.
// Assumes a 100 MHz core clock and a 16 word by 8 bit segment RAM.
package display_refresh_pkg;
    localparam int unsigned CLK_FREQ_HZ     = 100_000_000;
    localparam int unsigned SCAN_FREQ_HZ    = 2_000;
    // Longest scan period rounds down to whole cycles
    localparam int unsigned SCAN_DIV_CYCLES = CLK_FREQ_HZ / SCAN_FREQ_HZ;
    // Blanking at the start of every scan step, in cycles
    localparam int unsigned BLANK_CYCLES    = 16;
    localparam int unsigned SCAN_BITS       = 4;
    localparam int unsigned BLOCK_COUNT     = 16;
    localparam int unsigned SEG_BITS        = 8;
    localparam logic [3:0]  SCAN_RESET      = 4'h0;
    localparam logic [7:0]  SEG_BLANK       = 8'h00;
endpackage : display_refresh_pkg

/* File: logic/scan_timebase.sv */
// Free running scan tick generator for the display refresh.
// Assumes the package constants for clock rate and blanking length.
`timescale 1ns/1ps
module scan_timebase
(
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_reset_n,
    // Timing outputs
    output logic      o_scan_tick,
    output logic      o_blank
);
    localparam int unsigned DIV_LAST = display_refresh_pkg::SCAN_DIV_CYCLES - 1;

    logic [15:0] div_q;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
            div_q <= 16'h0000;
        else if (div_q == 16'(DIV_LAST))
            div_q <= 16'h0000;
        else
            div_q <= div_q + 16'h0001;
    end

    assign o_scan_tick = (div_q == 16'(DIV_LAST));
    // Blank while the new word settles, so old segments never show on a new anode
    assign o_blank     = (div_q < 16'(display_refresh_pkg::BLANK_CYCLES));

    chk_tick_period: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        o_scan_tick |=> !o_scan_tick [*8])
        else $error("Scan tick repeated too soon");
endmodule : scan_timebase

/* File: logic/multiplexed_display_refresh.sv */
// Multiplexed gas discharge display refresh: segment RAM, host write port,
// 2 kHz anode scan. Assumes host buses are synchronous to i_core_clk.
`timescale 1ns/1ps
module multiplexed_display_refresh
(
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_reset_n,
    // Host write port
    input  wire logic        i_display_write_strobe,
    input  wire logic [3:0]  i_host_addr,
    input  wire logic [7:0]  i_host_data,
    // Display drive
    output logic      [15:0] o_anode,
    output logic      [7:0]  o_segment,
    // Observation of RAM port
    output logic             o_ram_write,
    output logic             o_data_buf_en,
    output logic      [3:0]  o_ram_addr
);
    logic [3:0]  scan_q;
    logic        scan_tick;
    logic        blank;
    logic [7:0]  ram_q [display_refresh_pkg::BLOCK_COUNT];
    logic [3:0]  read_addr;
    logic [15:0] anode_d;
    logic [15:0] anode_q;
    logic [7:0]  segment_q;

    // Counter DCBA appears at the RAM as CBAD
    function automatic logic [3:0] rotate_left(input logic [3:0] v);
        rotate_left = {v[2:0], v[3]};
    endfunction : rotate_left

    // Count n lights odd block 2(n mod 8)+1, held as bit index 2(n mod 8)
    function automatic logic [3:0] anode_bit(input logic [3:0] v);
        anode_bit = {v[2:0], 1'b0};
    endfunction : anode_bit

    scan_timebase u_timebase
    (
        .i_core_clk  (i_core_clk),
        .i_reset_n   (i_reset_n),
        .o_scan_tick (scan_tick),
        .o_blank     (blank)
    );

    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
            scan_q <= display_refresh_pkg::SCAN_RESET;
        else if (scan_tick)
            scan_q <= scan_q + 4'h1;
    end

    assign read_addr     = rotate_left(scan_q);
    assign o_ram_write   = i_display_write_strobe;
    assign o_data_buf_en = i_display_write_strobe;
    // Host address while strobed, scan address otherwise
    assign o_ram_addr    = i_display_write_strobe ? i_host_addr : read_addr;

    // Host writes land one word per strobed cycle; no reset so it maps to RAM
    always_ff @(posedge i_core_clk)
    begin
        if (i_display_write_strobe)
            ram_q[o_ram_addr] <= i_host_data;
    end

    // Bit k of o_anode is block k+1; counts 8 to 15 repeat the odd blocks
    generate
        for (genvar k = 0; k < display_refresh_pkg::BLOCK_COUNT; k++)
        begin : g_anode
            assign anode_d[k] = (4'(k) == anode_bit(scan_q));
        end
    endgenerate

    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
            anode_q <= 16'h0000;
        else
            anode_q <= anode_d;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
            segment_q <= display_refresh_pkg::SEG_BLANK;
        else if (blank)
            segment_q <= display_refresh_pkg::SEG_BLANK;
        else
            segment_q <= ram_q[read_addr];
    end

    assign o_anode   = anode_q;
    assign o_segment = segment_q;

    // Checker helper: cycles since the last scan tick, for the period check
    logic [15:0] tick_gap_q;
    logic        tick_seen_q;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            tick_gap_q  <= 16'h0000;
            tick_seen_q <= 1'b0;
        end
        else if (scan_tick)
        begin
            tick_gap_q  <= 16'h0000;
            tick_seen_q <= 1'b1;
        end
        else
            tick_gap_q  <= tick_gap_q + 16'h0001;
    end

    chk_anode_onehot: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        $past(i_reset_n) |-> $onehot(o_anode))
        else $error("Anode select not one-hot");

    chk_anode_order: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        $past(i_reset_n) |-> o_anode[anode_bit($past(scan_q))])
        else $error("Anode order wrong");

    chk_anode_odd: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (o_anode & 16'haaaa) == 16'h0000)
        else $error("Even block anode driven");

    chk_anode_steady: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        $past(i_reset_n, 2) && $past(i_reset_n) && !$past(scan_tick, 2) |-> $stable(o_anode))
        else $error("Anode moved inside a scan step");

    chk_scan_advance: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        scan_tick |=> scan_q == $past(scan_q) + 4'h1)
        else $error("Scan count did not advance");

    chk_scan_hold: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        !scan_tick |=> $stable(scan_q))
        else $error("Scan count moved without tick");

    chk_tick_spacing: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        scan_tick && tick_seen_q |-> tick_gap_q == 16'(display_refresh_pkg::SCAN_DIV_CYCLES - 1))
        else $error("Scan tick period wrong");

    chk_scan_wrap: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        scan_tick && scan_q == 4'hf |=> scan_q == 4'h0)
        else $error("Scan count did not wrap");

    chk_blank_zero: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        blank |=> o_segment == 8'h00)
        else $error("Segments not blanked");

    chk_blank_step: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        scan_tick |=> blank)
        else $error("No blanking at step start");

    chk_blank_length: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        $rose(blank) |-> blank [*8] ##1 blank [*8] ##1 !blank)
        else $error("Blanking length wrong");

    chk_write_addr: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        i_display_write_strobe |-> o_ram_addr == i_host_addr && o_data_buf_en)
        else $error("Host address not selected");

    chk_write_land: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        i_display_write_strobe |=> ram_q[$past(i_host_addr)] == $past(i_host_data))
        else $error("Host word not stored");

    chk_read_addr: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        !i_display_write_strobe |-> o_ram_addr == {scan_q[2:0], scan_q[3]})
        else $error("Read address not rotated");

    chk_release_float: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        $fell(i_display_write_strobe) |-> !o_ram_write && !o_data_buf_en)
        else $error("Write not released");

    chk_buffer_idle: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        !i_display_write_strobe |-> !o_data_buf_en && !o_ram_write)
        else $error("Buffers driven without strobe");

    chk_segment_data: assert property (
        @(posedge i_core_clk) disable iff (!i_reset_n)
        !blank && !i_display_write_strobe |=> o_segment == ram_q[$past(read_addr)])
        else $error("Segment data mismatch");

    cov_wrap: cover property (@(posedge i_core_clk) scan_tick && scan_q == 4'hf);
    cov_write: cover property (@(posedge i_core_clk) $fell(i_display_write_strobe));
    cov_lit: cover property (@(posedge i_core_clk) !blank && o_segment != 8'h00);
    cov_burst: cover property (@(posedge i_core_clk) i_display_write_strobe && $past(i_display_write_strobe));
    cov_upper: cover property (@(posedge i_core_clk) scan_tick && scan_q == 4'h7);
endmodule : multiplexed_display_refresh

/* File: tb/host_bus_model.sv */
// Host side model: writes one segment word per strobed cycle.
// Assumes the bench calls its tasks and shares the core clock.
`timescale 1ns/1ps
module host_bus_model
(
    // Clock
    input  wire logic       i_core_clk,
    // Host write port
    output logic            o_strobe,
    output logic      [3:0] o_addr,
    output logic      [7:0] o_data
);
    initial
    begin
        o_strobe = 1'b0;
        o_addr   = 4'h0;
        o_data   = 8'h00;
    end

    // One word per strobed edge, back to back allowed
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        o_strobe <= 1'b1;
        o_addr   <= a;
        o_data   <= d;
    endtask : put

    // Released buses invert so stale values never look valid
    task automatic release_bus();
        @(posedge i_core_clk);
        o_strobe <= 1'b0;
        o_addr   <= ~o_addr;
        o_data   <= ~o_data;
    endtask : release_bus
endmodule : host_bus_model

/* File: tb/testbench.sv */
// Self-checking bench for the display refresh block.
// Assumes the fixed 50000 cycle scan step; covers the first two steps.
`timescale 1ns/1ps
module testbench;
    logic        i_core_clk = 1'b0;
    logic        i_reset_n  = 1'b0;
    logic        strobe;
    logic [3:0]  addr;
    logic [7:0]  data;
    logic [15:0] o_anode;
    logic [7:0]  o_segment;
    logic        o_ram_write;
    logic        o_data_buf_en;
    logic [3:0]  o_ram_addr;
    int          failures     = 0;
    int          total_checks = 0;
    int          cycles       = 0;

    always #5 i_core_clk = ~i_core_clk;

    host_bus_model host_bus_model_inst (.i_core_clk(i_core_clk), .o_strobe(strobe),
        .o_addr(addr), .o_data(data));
    multiplexed_display_refresh multiplexed_display_refresh_inst (
        .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_display_write_strobe(strobe),
        .i_host_addr(addr), .i_host_data(data), .o_anode(o_anode), .o_segment(o_segment),
        .o_ram_write(o_ram_write), .o_data_buf_en(o_data_buf_en), .o_ram_addr(o_ram_addr));

    task automatic end_sim();
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    task automatic chk(input bit ok, input string msg);
        total_checks++;
        if (!ok)
        begin
            failures++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask : chk

    // Back to back writes, then release to the scan address
    task automatic t_write();
        host_bus_model_inst.put(4'h0, 8'h5a);
        #1 chk(o_ram_write === 1'b1 && o_data_buf_en === 1'b1, "write state");
        chk(o_ram_addr === 4'h0, "host addr 0");
        host_bus_model_inst.put(4'h2, 8'ha5);
        #1 chk(o_ram_addr === 4'h2 && o_data_buf_en === 1'b1, "host addr 2");
        host_bus_model_inst.release_bus();
        #1 chk(o_ram_write === 1'b0 && o_data_buf_en === 1'b0, "release");
        chk(o_ram_addr === 4'h0, "scan addr");
    endtask : t_write

    // Step 0 shows block 1 with word 0
    task automatic t_step0();
        repeat (20) @(posedge i_core_clk);
        #1 chk(o_anode === 16'h0001, "anode step0");
        chk(o_segment === 8'h5a, "segment step0");
    endtask : t_step0

    // Step 1 blanks, then shows block 3 with word rotl(1)=2
    task automatic t_step1();
        for (int i = 0; i < 50100 && o_anode === 16'h0001; i++)
            @(posedge i_core_clk) #1;
        chk(o_segment === 8'h00, "blanking");
        chk(o_anode === 16'h0004, "anode step1");
        chk(o_ram_addr === 4'h2, "rotated addr");
        repeat (20) @(posedge i_core_clk);
        #1 chk(o_segment === 8'ha5 && o_anode === 16'h0004, "segment step1");
    endtask : t_step1

    // Two steps need about 50100 cycles
    always @(posedge i_core_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            failures++;
            end_sim();
        end
    end

    initial
    begin
        repeat (16) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        t_write();
        t_step0();
        t_step1();
        end_sim();
    end
endmodule : testbench
